// ---- uart_pkg.sv ----
// Shared constants for the dual serial port block: register map,
// field positions, reset values and frame sizes.
// Assumes one 50 MHz clock and a host bus of 8 data and 3 address bits.
package uart_pkg;
  // Sizes
  localparam int NUM_PORTS = 2;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int FIFO_DEPTH = 16;
  // Register offsets within one serial element
  localparam logic [2:0] REG_DATA = 3'h0;
  localparam logic [2:0] REG_DIVISOR = 3'h1;
  localparam logic [2:0] REG_CTRL = 3'h3;
  localparam logic [2:0] REG_MODEM_CTL = 3'h4;
  localparam logic [2:0] REG_LINE_STAT = 3'h5;
  localparam logic [2:0] REG_MODEM_STAT = 3'h6;
  localparam logic [2:0] REG_SCRATCH = 3'h7;
  // Register offset behind the parallel select
  localparam logic [2:0] REG_IRQ_MODE = 3'h0;
  // Field positions
  localparam int MCR_TERM_READY_BIT = 0;
  localparam int MCR_SEND_REQ_BIT = 1;
  localparam int MCR_LOOPBACK_BIT = 4;
  localparam int LSR_DATA_READY_BIT = 0;
  localparam int LSR_FRAME_ERR_BIT = 3;
  localparam int LSR_TX_ROOM_BIT = 5;
  localparam int MSR_CARRIER_BIT = 3;
  localparam int MSR_SEND_CLEAR_BIT = 4;
  localparam int MSR_SET_READY_BIT = 5;
  localparam int MSR_RING_BIT = 6;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int IRQ_COMPAT_BIT = 0;
  // Reset values
  localparam logic [7:0] DIVISOR_RST = 8'h0f;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic LINE_MARK = 1'b1;
  // Start bit, eight data bits, one stop bit
  localparam logic [3:0] FRAME_BITS = 4'ha;
endpackage

// ---- sync_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock; reset is synchronous.
`timescale 1ns/100ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Fill side
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  // Drain side
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t d;
  logic push;
  logic pop;

  // Honest flags straight from the fill count
  assign o_wr_ready = (q.cnt != (AW+1)'(DEPTH));
  assign o_rd_valid = (q.cnt != '0);
  assign o_rd_data = q.mem[q.rp];
  assign push = i_wr_valid & o_wr_ready;
  assign pop = i_rd_ready & o_rd_valid;

  // Pointer and count update; a push and a pop together keep the count
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = i_wr_data;
      d.wp = (q.wp == AW'(DEPTH - 1)) ? '0 : q.wp + AW'(1);
    end
    if (pop) begin
      d.rp = (q.rp == AW'(DEPTH - 1)) ? '0 : q.rp + AW'(1);
    end
    if (push && !pop) begin
      d.cnt = q.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      d.cnt = q.cnt - (AW+1)'(1);
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule // sync_fifo

// ---- dual_async_port.sv ----
// Two serial communication elements behind a strobed 8-bit host bus.
// Assumes host pins and modem lines are asynchronous to i_clk and are
// held steady for several clocks around each strobe.
`timescale 1ns/100ps
module dual_async_port (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Host bus
  input wire logic [uart_pkg::DATA_W-1:0] i_host_data,
  output logic [uart_pkg::DATA_W-1:0] o_host_data,
  output logic o_host_data_oe_n,
  input wire logic [uart_pkg::ADDR_W-1:0] i_register_select_lines,
  input wire logic i_io_write_strobe,
  input wire logic i_io_read_strobe,
  input wire logic i_serial0_select,
  input wire logic i_serial1_select,
  input wire logic i_parallel_select,
  // Serial and modem lines, one bit per element
  output logic [uart_pkg::NUM_PORTS-1:0] o_serial_tx_line,
  input wire logic [uart_pkg::NUM_PORTS-1:0] i_serial_rx_line,
  output logic [uart_pkg::NUM_PORTS-1:0] o_terminal_ready_out,
  output logic [uart_pkg::NUM_PORTS-1:0] o_send_request_out,
  input wire logic [uart_pkg::NUM_PORTS-1:0] i_send_clear_in,
  input wire logic [uart_pkg::NUM_PORTS-1:0] i_set_ready_in,
  input wire logic [uart_pkg::NUM_PORTS-1:0] i_ring_detect_in,
  input wire logic [uart_pkg::NUM_PORTS-1:0] i_carrier_detect_in,
  // Interrupt mux mode
  output logic o_interrupt_request_mux_compat
);
  import uart_pkg::*;

  // Modem input order inside the synchroniser: ring, ready, clear, carrier
  typedef struct packed {
    logic [1:0] wr_s;
    logic [1:0] rd_s;
    logic wr_prev;
    logic [2:0] cs_a;
    logic [2:0] cs_b;
    logic [2:0] adr_a;
    logic [2:0] adr_b;
    logic [7:0] dat_a;
    logic [7:0] dat_b;
    logic [1:0] rx_a;
    logic [1:0] rx_b;
    logic [1:0][3:0] mdm_a;
    logic [1:0][3:0] mdm_b;
    logic [1:0][7:0] mcr;
    logic [1:0][7:0] div;
    logic [1:0][7:0] ctl;
    logic [1:0][7:0] scr;
    logic [1:0][7:0] rbr;
    logic [1:0][7:0] rx_sh;
    logic [1:0][9:0] tx_sh;
    logic [1:0][3:0] tx_bits;
    logic [1:0][3:0] rx_bits;
    logic [1:0][7:0] tx_cnt;
    logic [1:0][7:0] rx_cnt;
    logic [1:0] dr;
    logic [1:0] ferr;
    logic [1:0] rx_busy;
    logic [1:0] tx_line;
    logic irq_compat;
    logic [7:0] dout;
    logic dout_oe_n;
  } state_t;

  state_t q;
  state_t d;
  logic wr_fire;
  logic [1:0] fifo_wr_valid;
  logic [1:0] fifo_wr_ready;
  logic [1:0] fifo_rd_valid;
  logic [1:0] tx_take;
  logic [1:0][7:0] fifo_rd_data;

  // Only the second synchroniser stage of each strobe is looked at
  assign wr_fire = q.wr_s[1] & ~q.wr_prev;

  // Transmit queues; a full queue refuses further data writes
  for (genvar e = 0; e < NUM_PORTS; e++) begin : g_port
    assign fifo_wr_valid[e] = wr_fire & q.cs_b[e] & (q.adr_b == REG_DATA);
    // New frame only when idle and software has enabled transfers
    assign tx_take[e] = fifo_rd_valid[e] & (q.tx_bits[e] == 4'h0)
                      & q.ctl[e][CTRL_ENABLE_BIT];
    sync_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_wr_valid(fifo_wr_valid[e]),
      .o_wr_ready(fifo_wr_ready[e]),
      .i_wr_data(q.dat_b),
      .o_rd_valid(fifo_rd_valid[e]),
      .i_rd_ready(tx_take[e]),
      .o_rd_data(fifo_rd_data[e])
    );
  end

  // Next state: synchronisers, register access, transmit, receive
  always_comb begin
    logic rx;
    logic [7:0] rv;
    rx = 1'b1;
    rv = 8'h00;
    d = q;
    d.wr_s = {q.wr_s[0], i_io_write_strobe};
    d.rd_s = {q.rd_s[0], i_io_read_strobe};
    d.wr_prev = q.wr_s[1];
    d.cs_a = {i_parallel_select, i_serial1_select, i_serial0_select};
    d.cs_b = q.cs_a;
    d.adr_a = i_register_select_lines;
    d.adr_b = q.adr_a;
    d.dat_a = i_host_data;
    d.dat_b = q.dat_a;
    d.rx_a = i_serial_rx_line;
    d.rx_b = q.rx_a;
    for (int e = 0; e < NUM_PORTS; e++) begin
      d.mdm_a[e] = {i_ring_detect_in[e], i_set_ready_in[e],
                    i_send_clear_in[e], i_carrier_detect_in[e]};
    end
    d.mdm_b = q.mdm_a;
    d.dout = 8'h00;
    if (wr_fire && q.cs_b[2] && q.adr_b == REG_IRQ_MODE) begin
      d.irq_compat = q.dat_b[IRQ_COMPAT_BIT];
    end
    if (q.cs_b[2] && q.adr_b == REG_IRQ_MODE) begin
      d.dout[IRQ_COMPAT_BIT] = q.irq_compat;
    end
    for (int e = 0; e < NUM_PORTS; e++) begin
      // Host writes to the addressed register of the selected element
      if (wr_fire && q.cs_b[e]) begin
        case (q.adr_b)
          REG_DIVISOR: d.div[e] = q.dat_b;
          REG_CTRL: d.ctl[e] = q.dat_b;
          REG_MODEM_CTL: d.mcr[e] = q.dat_b;
          REG_SCRATCH: d.scr[e] = q.dat_b;
          default: ;
        endcase
      end
      // Read mux for the addressed register
      case (q.adr_b)
        REG_DATA: rv = q.rbr[e];
        REG_DIVISOR: rv = q.div[e];
        REG_CTRL: rv = q.ctl[e];
        REG_MODEM_CTL: rv = q.mcr[e];
        REG_LINE_STAT: begin
          rv = 8'h00;
          rv[LSR_DATA_READY_BIT] = q.dr[e];
          rv[LSR_FRAME_ERR_BIT] = q.ferr[e];
          rv[LSR_TX_ROOM_BIT] = fifo_wr_ready[e];
        end
        REG_MODEM_STAT: begin
          rv = 8'h00;
          rv[MSR_CARRIER_BIT] = q.mdm_b[e][0];
          rv[MSR_SEND_CLEAR_BIT] = q.mdm_b[e][1];
          rv[MSR_SET_READY_BIT] = q.mdm_b[e][2];
          rv[MSR_RING_BIT] = q.mdm_b[e][3];
        end
        REG_SCRATCH: rv = q.scr[e];
        default: rv = 8'h00;
      endcase
      if (q.cs_b[e]) begin
        d.dout = rv;
      end
      // Reading the data register consumes it; a new byte below wins
      if (q.rd_s[1] && q.cs_b[e] && q.adr_b == REG_DATA) begin
        d.dr[e] = 1'b0;
      end
      // Transmitter: frame LSB first, each bit lasts divisor+1 clocks
      if (q.tx_bits[e] == 4'h0) begin
        d.tx_line[e] = LINE_MARK;
        if (tx_take[e]) begin
          d.tx_sh[e] = {1'b1, fifo_rd_data[e], 1'b0};
          d.tx_bits[e] = FRAME_BITS;
          d.tx_cnt[e] = q.div[e];
          d.tx_line[e] = 1'b0;
        end
      end else if (q.tx_cnt[e] != 8'h00) begin
        d.tx_cnt[e] = q.tx_cnt[e] - 8'h01;
      end else begin
        d.tx_sh[e] = {1'b1, q.tx_sh[e][9:1]};
        d.tx_line[e] = q.tx_sh[e][1];
        d.tx_bits[e] = q.tx_bits[e] - 4'h1;
        d.tx_cnt[e] = q.div[e];
      end
      // Receiver source: own transmit line in loopback
      rx = q.mcr[e][MCR_LOOPBACK_BIT] ? q.tx_line[e] : q.rx_b[e];
      if (!q.rx_busy[e]) begin
        // Disabled elements ignore line activity, as after reset
        if (!rx && q.ctl[e][CTRL_ENABLE_BIT]) begin
          d.rx_busy[e] = 1'b1;
          d.rx_bits[e] = FRAME_BITS;
          d.rx_cnt[e] = {1'b0, q.div[e][7:1]}; // Sample mid-bit
        end
      end else if (q.rx_cnt[e] != 8'h00) begin
        d.rx_cnt[e] = q.rx_cnt[e] - 8'h01;
      end else begin
        d.rx_cnt[e] = q.div[e];
        d.rx_bits[e] = q.rx_bits[e] - 4'h1;
        if (q.rx_bits[e] == FRAME_BITS) begin
          d.rx_busy[e] = ~rx; // Glitch shorter than half a bit
        end else if (q.rx_bits[e] == 4'h1) begin
          d.rx_busy[e] = 1'b0;
          d.rbr[e] = q.rx_sh[e];
          d.dr[e] = 1'b1;
          d.ferr[e] = ~rx;
        end else begin
          d.rx_sh[e] = {rx, q.rx_sh[e][7:1]};
        end
      end
    end
    // Drive the bus only during a selected read
    d.dout_oe_n = ~(q.rd_s[1] & (|q.cs_b));
  end

  // State register; reset forces idle lines and non-compatible mux
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q <= '0;
      q.tx_line <= {NUM_PORTS{LINE_MARK}};
      q.div <= {NUM_PORTS{DIVISOR_RST}};
      q.mcr <= {NUM_PORTS{MCR_RST}};
      q.ctl <= {NUM_PORTS{CTRL_RST}};
      q.irq_compat <= 1'b0;
      q.dout_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign o_serial_tx_line = q.tx_line;
  assign o_host_data = q.dout;
  assign o_host_data_oe_n = q.dout_oe_n;
  assign o_interrupt_request_mux_compat = q.irq_compat;
  for (genvar e = 0; e < NUM_PORTS; e++) begin : g_modem
    assign o_terminal_ready_out[e] = q.mcr[e][MCR_TERM_READY_BIT];
    assign o_send_request_out[e] = q.mcr[e][MCR_SEND_REQ_BIT];
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_wr_mcr0;
    wr_fire && q.cs_b[0] && q.adr_b == REG_MODEM_CTL;
  endsequence
  sequence s_tx_load0;
    tx_take[0] ##1 (o_serial_tx_line[0] == 1'b0);
  endsequence

  property p_tx_mark_after_reset;
    $rose(i_rst_n) |-> (o_serial_tx_line == 2'b11);
  endproperty
  a_tx_mark_after_reset: assert property (p_tx_mark_after_reset)
    else $error("transmit line not marking after reset");

  property p_term_ready;
    s_wr_mcr0 |=> ##1 (o_terminal_ready_out[0] == $past(q.dat_b[0], 2));
  endproperty
  a_term_ready: assert property (p_term_ready)
    else $error("terminal ready does not follow control bit 0");

  property p_send_req;
    s_wr_mcr0 |=> ##1 (o_send_request_out[0] == $past(q.dat_b[1], 2));
  endproperty
  a_send_req: assert property (p_send_req)
    else $error("send request does not follow control bit 1");

  property p_loop_ignores_pin;
    (q.mcr[0][MCR_LOOPBACK_BIT] && q.tx_line[0] && !q.rx_busy[0])
      |=> !q.rx_busy[0];
  endproperty
  a_loop_ignores_pin: assert property (p_loop_ignores_pin)
    else $error("receiver started from pin during loopback");

  property p_bus_released;
    !(q.rd_s[1] && (|q.cs_b)) |=> o_host_data_oe_n;
  endproperty
  a_bus_released: assert property (p_bus_released)
    else $error("bus driven without a selected read");

  property p_msr_clear;
    (q.rd_s[1] && q.cs_b[0] && q.adr_b == REG_MODEM_STAT && !q.cs_b[1])
      |=> (o_host_data[MSR_SEND_CLEAR_BIT] == $past(q.mdm_b[0][1]));
  endproperty
  a_msr_clear: assert property (p_msr_clear)
    else $error("modem status bit 4 wrong");

  property p_scratch_write;
    (wr_fire && q.cs_b[1] && q.adr_b == REG_SCRATCH)
      |=> (q.scr[1] == $past(q.dat_b));
  endproperty
  a_scratch_write: assert property (p_scratch_write)
    else $error("scratch register not loaded");

  property p_idle_until_enabled;
    (!q.ctl[0][CTRL_ENABLE_BIT] && q.tx_bits[0] == 4'h0)
      |=> o_serial_tx_line[0];
  endproperty
  a_idle_until_enabled: assert property (p_idle_until_enabled)
    else $error("transmit while transfers disabled");

  property p_mux_mode_reset;
    $rose(i_rst_n) |-> !o_interrupt_request_mux_compat;
  endproperty
  a_mux_mode_reset: assert property (p_mux_mode_reset)
    else $error("interrupt mux not in non-compatible mode");

  property p_start_bit;
    s_tx_load0 |-> (q.tx_sh[0][1] == $past(fifo_rd_data[0][0]));
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("first data bit is not the LSB");
endmodule // dual_async_port

// ---- modem_model.sv ----
// Far-side model of the modem and serial link for both ports.
// It sends 8N1 frames on the receive lines and decodes the frames
// that it sees on the transmit lines.
// Assumes a bit time of BIT_CLKS cycles of i_clk, matching the divisor.
`timescale 1ns/100ps
module modem_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input wire logic i_clk,
  // Serial lines seen from the far side
  input wire logic [1:0] i_serial_tx_line,
  output logic [1:0] o_serial_rx_line
);
  logic [7:0] got_q[2][$];

  // An idle link rests at mark
  initial o_serial_rx_line = 2'b11;

  // Start bit, eight data bits LSB first, stop bit
  task automatic send_byte(input int p, input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      o_serial_rx_line[p] <= fr[i];
      repeat (BIT_CLKS - 1) @(posedge i_clk);
    end
  endtask

  // Sampled on the falling edge, away from the line's own changes
  for (genvar p = 0; p < 2; p++) begin : g_mon
    initial begin : mon
      logic [7:0] b;
      forever begin
        do begin
          @(negedge i_clk);
        end while (i_serial_tx_line[p] !== 1'b0);
        repeat (BIT_CLKS / 2) @(negedge i_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CLKS) @(negedge i_clk);
          b[i] = i_serial_tx_line[p];
        end
        repeat (BIT_CLKS) @(negedge i_clk);
        // A frame with a bad stop bit is dropped, so counts reveal it
        if (i_serial_tx_line[p] === 1'b1) begin
          got_q[p].push_back(b);
        end
      end
    end
  end
endmodule // modem_model

// ---- dual_async_port_bench.sv ----
// Self-checking bench for the dual serial port block.
// Assumes the modem model sits on the serial lines and the bench drives
// the host bus and the modem status inputs.
`timescale 1ns/100ps
module dual_async_port_bench;
  import uart_pkg::*;
  logic clk, rst_n, wr, rd, oe_n, irq;
  logic [2:0] sel, addr;
  logic [7:0] wdata, host_q;
  logic [1:0] tx, rx, term, sreq, cts, dsr, ri, dcd;
  logic [3:0] pat;
  int num_errors = 0;
  int num_checks = 0;

  dual_async_port dual_async_port_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_host_data(wdata),
    .o_host_data(host_q), .o_host_data_oe_n(oe_n),
    .i_register_select_lines(addr), .i_io_write_strobe(wr),
    .i_io_read_strobe(rd), .i_serial0_select(sel[0]),
    .i_serial1_select(sel[1]), .i_parallel_select(sel[2]),
    .o_serial_tx_line(tx), .i_serial_rx_line(rx),
    .o_terminal_ready_out(term), .o_send_request_out(sreq),
    .i_send_clear_in(cts), .i_set_ready_in(dsr),
    .i_ring_detect_in(ri), .i_carrier_detect_in(dcd),
    .o_interrupt_request_mux_compat(irq)
  );

  modem_model modem_model_i (
    .i_clk(clk), .i_serial_tx_line(tx), .o_serial_rx_line(rx)
  );

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  // One strobed access; select, address and data settle 3 clocks before
  // the strobe and stay until the strobe has been low for a while
  task automatic bus(input logic w, input logic [2:0] s,
                     input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    sel <= s;
    addr <= a;
    wdata <= d;
    repeat (3) @(posedge clk);
    wr <= w;
    rd <= !w;
    repeat (5) @(posedge clk);
    q = host_q;
    chk({7'h00, oe_n}, {7'h00, w}, "bus drive");
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (4) @(posedge clk);
    sel <= 3'b000;
    chk({7'h00, oe_n}, 8'h01, "bus release");
  endtask

  task automatic wr_reg(input logic [2:0] s, input logic [2:0] a,
                        input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, s, a, d, q);
  endtask

  task automatic rd_chk(input logic [2:0] s, input logic [2:0] a,
                        input logic [7:0] m, input logic [7:0] e,
                        input string what);
    logic [7:0] q;
    bus(1'b0, s, a, 8'h00, q);
    chk(q & m, e, what);
  endtask

  // Bounded wait for a received byte to be flagged
  task automatic poll_ready(input int p);
    logic [7:0] q;
    for (int k = 0; k < 40; k++) begin
      bus(1'b0, 3'(1 << p), REG_LINE_STAT, 8'h00, q);
      if (q[LSR_DATA_READY_BIT] === 1'b1) return;
    end
    num_errors++;
    $display("wrong value at %0t: receive flag never set", $time);
    results();
  endtask

  task automatic wait_tx(input int p, input int n);
    int k;
    k = 0;
    while (modem_model_i.got_q[p].size() < n && k < 6000) begin
      @(posedge clk);
      k++;
    end
    if (k == 6000) begin
      num_errors++;
      $display("wrong value at %0t: serial frames missing", $time);
      results();
    end
  endtask

  function automatic logic [7:0] msr(input logic [3:0] m);
    msr = 8'h00;
    msr[MSR_SEND_CLEAR_BIT] = m[0];
    msr[MSR_SET_READY_BIT] = m[1];
    msr[MSR_RING_BIT] = m[2];
    msr[MSR_CARRIER_BIT] = m[3];
  endfunction

  initial begin
    rst_n = 1'b0;
    {wr, rd, sel, addr, wdata} = '0;
    {cts, dsr, ri, dcd} = '0;
    do_reset();
    // Reset state of the pins and of the registers
    chk({6'h00, tx}, 8'h03, "tx idle");
    chk({4'h0, term, sreq}, 8'h00, "modem outputs");
    chk({7'h00, irq}, 8'h00, "irq mode");
    for (int p = 0; p < 2; p++) begin
      rd_chk(3'(1 << p), REG_DIVISOR, 8'hff, DIVISOR_RST, "div");
      rd_chk(3'(1 << p), REG_CTRL, 8'hff, CTRL_RST, "ctrl");
    end
    // Divisor is writable; put back the bit time the modem model expects
    wr_reg(3'b001, REG_DIVISOR, 8'h2d);
    rd_chk(3'b001, REG_DIVISOR, 8'hff, 8'h2d, "div write");
    wr_reg(3'b001, REG_DIVISOR, DIVISOR_RST);
    // Each port's modem control drives only its own pins
    for (int p = 0; p < 2; p++) begin
      for (int v = 1; v < 5; v++) begin
        wr_reg(3'(1 << p), REG_MODEM_CTL, 8'(v & 3));
        chk({6'h00, term}, 8'(v & 1) << p, "terminal ready");
        chk({6'h00, sreq}, 8'((v >> 1) & 1) << p, "send request");
      end
    end
    wr_reg(3'b001, REG_SCRATCH, 8'ha5);
    wr_reg(3'b010, REG_SCRATCH, 8'h5a);
    rd_chk(3'b001, REG_SCRATCH, 8'hff, 8'ha5, "scratch 0");
    rd_chk(3'b010, REG_SCRATCH, 8'hff, 8'h5a, "scratch 1");
    // Modem status, one input at a time, ports opposite
    for (int k = 0; k < 4; k++) begin
      pat = 4'(1 << k);
      @(posedge clk);
      cts <= {~pat[0], pat[0]};
      dsr <= {~pat[1], pat[1]};
      ri <= {~pat[2], pat[2]};
      dcd <= {~pat[3], pat[3]};
      rd_chk(3'b001, REG_MODEM_STAT, 8'h78, msr(pat), "msr 0");
      rd_chk(3'b010, REG_MODEM_STAT, 8'h78, msr(~pat), "msr 1");
    end
    // Transfers still disabled: 16 bytes fill the queue, one more is lost
    for (int i = 0; i < 17; i++) begin
      wr_reg(3'b010, REG_DATA, 8'(i * 13 + 7));
    end
    rd_chk(3'b010, REG_LINE_STAT, 8'h20, 8'h00, "tx full");
    chk({6'h00, tx}, 8'h03, "tx held");
    // A frame on a disabled element must not be received
    modem_model_i.send_byte(0, 8'h81);
    rd_chk(3'b001, REG_LINE_STAT, 8'h01, 8'h00, "rx disabled");
    wr_reg(3'b010, REG_CTRL, 8'h01);
    wait_tx(1, 16);
    for (int i = 0; i < 16; i++) begin
      chk(modem_model_i.got_q[1][i], 8'(i * 13 + 7), "tx byte");
    end
    rd_chk(3'b010, REG_LINE_STAT, 8'h20, 8'h20, "tx room");
    // Receive on port 1 only
    modem_model_i.send_byte(1, 8'hc6);
    poll_ready(1);
    rd_chk(3'b001, REG_LINE_STAT, 8'h01, 8'h00, "port 0 quiet");
    rd_chk(3'b010, REG_DATA, 8'hff, 8'hc6, "rx byte");
    chk(8'(modem_model_i.got_q[1].size()), 8'h10, "tx count");
    chk(8'(modem_model_i.got_q[0].size()), 8'h00, "tx 0 count");
    // Loopback on port 0 while the pin carries a different byte
    wr_reg(3'b001, REG_CTRL, 8'h01);
    wr_reg(3'b001, REG_MODEM_CTL, 8'h10);
    fork
      modem_model_i.send_byte(0, 8'h5a);
      wr_reg(3'b001, REG_DATA, 8'h3c);
    join
    poll_ready(0);
    rd_chk(3'b001, REG_DATA, 8'hff, 8'h3c, "loopback");
    // Interrupt mux mode, then a second reset
    wr_reg(3'b100, REG_IRQ_MODE, 8'h01);
    chk({7'h00, irq}, 8'h01, "irq compat");
    rd_chk(3'b100, REG_IRQ_MODE, 8'h01, 8'h01, "irq read");
    wr_reg(3'b010, REG_MODEM_CTL, 8'h03);
    do_reset();
    chk({7'h00, irq}, 8'h00, "irq after reset");
    chk({6'h00, tx}, 8'h03, "tx after reset");
    chk({4'h0, term, sreq}, 8'h00, "modem after reset");
    rd_chk(3'b010, REG_CTRL, 8'hff, CTRL_RST, "ctrl after reset");
    results();
  end
endmodule // dual_async_port_bench
